// ### hdl/channel_dma_sequencers.sv
// One channel DMA sequencer, kind chosen by SEQ_KIND
// Functional notes
// - accept requests from 32 channels, detect new
// - fetch channel descriptor from Sram before data
// - Sram/PCI kinds: Sram, PCI addresses, endian, size
// - dram-to-Sram: dram, Sram addresses, size only
// - Sram-to-dram adds checksum reset flag
// - PCI-to-dram: fill fifo first, then dram write
// - PCI-to-dram data always staged in Sram fifo
// - Sram-to-PCI requests go to master-out
// - PCI-to-Sram requests go to master-in
// - dram-to-Sram requests go to dram read
// - Sram-to-dram requests go to dram write
// - repeat sub-requests until full size moved
// - write ending status, then set done bit
// - afterwards return to watching channels
// - slave to channels, master to sequencers
`include "dma_seq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module channel_dma_sequencers #(
    parameter logic [2:0] SEQ_KIND = `SEQ_P2D
) (
    input  wire logic                   CLK_SYS,
    input  wire logic                   SYS_RST,
    input  wire logic [31:0]            CHAN_REQ,
    output logic      [31:0]            CHAN_DONE,
    output logic                        SRAM_REQ,
    output logic                        SRAM_WR,
    output logic      [15:0]            SRAM_ADDR,
    output logic      [31:0]            SRAM_WDATA,
    input  wire logic                   SRAM_ACK,
    input  wire logic [31:0]            SRAM_RDATA,
    output dma_seq_pkg::xfer_req_t      SLV_A,
    input  wire logic                   SLV_A_ACK,
    input  wire logic [8:0]             SLV_A_SIZE,
    output dma_seq_pkg::xfer_req_t      SLV_B,
    input  wire logic                   SLV_B_ACK,
    input  wire logic [8:0]             SLV_B_SIZE,
    output logic                        BUSY
);
    import dma_seq_pkg::*;

    localparam logic STAGED = (SEQ_KIND == `SEQ_P2D);

    seq_state_t  state;
    logic [31:0] req_q;
    logic [31:0] pend;
    logic [31:0] take_mask;
    logic [4:0]  cur_chan;
    logic [1:0]  fetch_idx;
    logic [31:0] addr0;
    logic [31:0] addr1;
    logic [15:0] remain;
    logic [15:0] moved;
    logic        swap;
    logic        ckrst;
    logic        ovr;
    logic [8:0]  chunk_left;
    logic [8:0]  chunk_len;
    logic [8:0]  fifo_off;
    logic        cur_ack;
    logic [8:0]  cur_size;
    logic [8:0]  ab;
    logic        last_ack;

    function automatic logic [4:0] lowest(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 31; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] dscr_addr(input logic [4:0] ch,
                                              input logic [1:0] w);
        return 16'(`DSCR_BASE + {7'h00, ch, w, 2'b00});
    endfunction

    function automatic logic [8:0] clamp(input logic [8:0] sz,
                                         input logic [8:0] lim);
        return (sz > lim) ? lim : sz;
    endfunction

    function automatic logic [8:0] chunk_of(input logic [15:0] r);
        return (r > {7'h00, `CHUNK_MAX}) ? `CHUNK_MAX : r[8:0];
    endfunction

    // New request is a rising level; set beats the clear of acceptance
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            req_q <= 32'h00000000;
            pend  <= 32'h00000000;
        end
        else
        begin
            req_q <= CHAN_REQ;
            pend  <= (pend & ~take_mask) | (CHAN_REQ & ~req_q);
        end
    end

    always_comb
    begin
        take_mask = 32'h00000000;
        if (state == ST_IDLE && pend != 32'h00000000)
        begin
            take_mask[lowest(pend)] = 1'b1;
        end
    end

    always_comb
    begin
        cur_ack  = (state == ST_XFER_A) ? SLV_A_ACK :
                   (state == ST_XFER_B) ? SLV_B_ACK : 1'b0;
        cur_size = (state == ST_XFER_B) ? SLV_B_SIZE : SLV_A_SIZE;
        ab       = clamp(cur_size, chunk_left);
        last_ack = cur_ack && (ab == chunk_left);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            state      <= ST_IDLE;
            cur_chan   <= 5'h00;
            fetch_idx  <= 2'h0;
            addr0      <= 32'h00000000;
            addr1      <= 32'h00000000;
            remain     <= 16'h0000;
            moved      <= 16'h0000;
            swap       <= 1'b0;
            ckrst      <= 1'b0;
            ovr        <= 1'b0;
            chunk_left <= 9'h000;
            chunk_len  <= 9'h000;
            fifo_off   <= 9'h000;
            SRAM_REQ   <= 1'b0;
            SRAM_WR    <= 1'b0;
            SRAM_ADDR  <= 16'h0000;
            SRAM_WDATA <= 32'h00000000;
            SLV_A      <= '0;
            SLV_B      <= '0;
            CHAN_DONE  <= 32'h00000000;
            BUSY       <= 1'b0;
        end
        else
        begin
            CHAN_DONE <= 32'h00000000;
            case (state)
                ST_IDLE:
                begin
                    BUSY <= 1'b0;
                    if (pend != 32'h00000000)
                    begin
                        cur_chan  <= lowest(pend);
                        fetch_idx <= `DSCR_W_ADDR0;
                        SRAM_REQ  <= 1'b1;
                        SRAM_WR   <= 1'b0;
                        SRAM_ADDR <= dscr_addr(lowest(pend), `DSCR_W_ADDR0);
                        moved     <= 16'h0000;
                        ovr       <= 1'b0;
                        BUSY      <= 1'b1;
                        state     <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    if (SRAM_ACK)
                    begin
                        case (fetch_idx)
                            `DSCR_W_ADDR0: addr0 <= SRAM_RDATA;
                            `DSCR_W_ADDR1: addr1 <= SRAM_RDATA;
                            default:
                            begin
                                remain <= SRAM_RDATA[`CTRL_SIZE_MSB:0];
                                // Endian only for PCI kinds, reset for S2D
                                swap   <= SRAM_RDATA[`CTRL_SWAP_BIT] &&
                                          (SEQ_KIND == `SEQ_P2D ||
                                           SEQ_KIND == `SEQ_S2P ||
                                           SEQ_KIND == `SEQ_P2S);
                                ckrst  <= SRAM_RDATA[`CTRL_CKRST_BIT] &&
                                          (SEQ_KIND == `SEQ_S2D);
                            end
                        endcase
                        if (fetch_idx == `DSCR_W_CTRL)
                        begin
                            SRAM_REQ <= 1'b0;
                            state    <= ST_ISSUE;
                        end
                        else
                        begin
                            fetch_idx <= 2'(fetch_idx + 2'h1);
                            SRAM_ADDR <= dscr_addr(cur_chan,
                                                   2'(fetch_idx + 2'h1));
                        end
                    end
                end
                ST_ISSUE:
                begin
                    if (remain == 16'h0000)
                    begin
                        SRAM_REQ   <= 1'b1;
                        SRAM_WR    <= 1'b1;
                        SRAM_ADDR  <= dscr_addr(cur_chan, `DSCR_W_STATUS);
                        SRAM_WDATA <= {1'b1, ovr, 14'h0000, moved};
                        state      <= ST_STATUS;
                    end
                    else
                    begin
                        // Each chunk is a fresh sub-request
                        chunk_left    <= chunk_of(remain);
                        chunk_len     <= chunk_of(remain);
                        fifo_off      <= 9'h000;
                        SLV_A.req     <= 1'b1;
                        SLV_A.len     <= chunk_of(remain);
                        SLV_A.swap    <= swap;
                        SLV_A.cksum_rst <= ckrst;
                        case (SEQ_KIND)
                            `SEQ_P2D:
                            begin
                                SLV_A.src <= addr1;
                                SLV_A.dst <= `FIFO_BASE;
                            end
                            `SEQ_S2P:
                            begin
                                SLV_A.src <= addr0;
                                SLV_A.dst <= addr1;
                            end
                            `SEQ_P2S:
                            begin
                                SLV_A.src <= addr1;
                                SLV_A.dst <= addr0;
                            end
                            `SEQ_D2S:
                            begin
                                SLV_A.src <= addr0;
                                SLV_A.dst <= addr1;
                            end
                            default:
                            begin
                                SLV_A.src <= addr1;
                                SLV_A.dst <= addr0;
                            end
                        endcase
                        ckrst <= 1'b0;
                        state <= ST_XFER_A;
                    end
                end
                ST_XFER_A:
                begin
                    if (cur_ack)
                    begin
                        if (cur_size > chunk_left)
                        begin
                            ovr <= 1'b1;
                        end
                        chunk_left <= 9'(chunk_left - ab);
                        addr1 <= addr1 + {23'h000000, ab};
                        if (!STAGED)
                        begin
                            remain <= 16'(remain - {7'h00, ab});
                            moved  <= 16'(moved + {7'h00, ab});
                        end
                        if (!STAGED && SEQ_KIND != `SEQ_S2D)
                        begin
                            addr0 <= addr0 + {23'h000000, ab};
                        end
                        if (SEQ_KIND == `SEQ_S2D)
                        begin
                            // S2D walks both; addr0 is dram here too
                            addr0 <= addr0 + {23'h000000, ab};
                        end
                    end
                    if (last_ack)
                    begin
                        SLV_A.req <= 1'b0;
                        if (STAGED)
                        begin
                            // Fifo now full of this chunk; drain it
                            SLV_B.req  <= 1'b1;
                            SLV_B.src  <= `FIFO_BASE;
                            SLV_B.dst  <= addr0;
                            SLV_B.len  <= chunk_len;
                            SLV_B.swap <= 1'b0;
                            SLV_B.cksum_rst <= 1'b0;
                            chunk_left <= chunk_len;
                            state      <= ST_XFER_B;
                        end
                        else
                        begin
                            state <= ST_ISSUE;
                        end
                    end
                end
                ST_XFER_B:
                begin
                    if (cur_ack)
                    begin
                        if (cur_size > chunk_left)
                        begin
                            ovr <= 1'b1;
                        end
                        chunk_left <= 9'(chunk_left - ab);
                        fifo_off   <= 9'(fifo_off + ab);
                        addr0  <= addr0 + {23'h000000, ab};
                        remain <= 16'(remain - {7'h00, ab});
                        moved  <= 16'(moved + {7'h00, ab});
                    end
                    if (last_ack)
                    begin
                        SLV_B.req <= 1'b0;
                        state     <= ST_ISSUE;
                    end
                end
                ST_STATUS:
                begin
                    if (SRAM_ACK)
                    begin
                        SRAM_REQ <= 1'b0;
                        SRAM_WR  <= 1'b0;
                        CHAN_DONE[cur_chan] <= 1'b1;
                        state    <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    BUSY  <= 1'b0;
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    chk_done_onehot: assert property ($onehot0(CHAN_DONE))
        else $error("more than one done bit");
    chk_done_after_status: assert property (
        CHAN_DONE != 32'h0 |-> $past(state == ST_STATUS && SRAM_ACK)
        && CHAN_DONE[$past(cur_chan)])
        else $error("done bit without status write");
    chk_status_write: assert property (
        state == ST_STATUS |-> SRAM_REQ && SRAM_WR
        && SRAM_WDATA[`STAT_DONE_BIT] && SRAM_ADDR[3:2] == `DSCR_W_STATUS)
        else $error("status write malformed");
    chk_fetch_first: assert property (
        $rose(SLV_A.req) |-> $past(state == ST_ISSUE)
        && $past(state, 2) != ST_IDLE)
        else $error("slave request before descriptor fetch");
    chk_lowest_first: assert property (
        state == ST_IDLE && pend != 32'h0 |=> state == ST_FETCH
        && cur_chan == lowest($past(pend)))
        else $error("wrong channel chosen");
    chk_new_req_seen: assert property (
        state != ST_IDLE && $rose(CHAN_REQ[0]) |=> pend[0])
        else $error("new channel request lost");
    chk_remain_step: assert property (
        cur_ack && (state == ST_XFER_B || !STAGED)
        |=> remain == 16'($past(remain) - {7'h00, $past(ab)}))
        else $error("count not reduced by acked size");
    chk_repeat_until: assert property (
        state == ST_ISSUE && remain != 16'h0 |=> state == ST_XFER_A
        && SLV_A.req)
        else $error("transfer ended before size moved");
    chk_staged_order: assert property (
        $rose(SLV_B.req) |-> STAGED && $past(state == ST_XFER_A)
        && !SLV_A.req && SLV_B.src == `FIFO_BASE)
        else $error("dram write not after fifo fill");
    chk_back_to_idle: assert property (
        $rose(CHAN_DONE != 32'h0) |-> state == ST_DONE ##1 state == ST_IDLE)
        else $error("did not return to channel watch");

    cov_full_job: cover property (
        state == ST_FETCH ##[1:300] state == ST_STATUS
        ##[1:20] state == ST_DONE);
    cov_two_chunks: cover property (
        state == ST_XFER_A ##[1:600] state == ST_ISSUE ##1 state == ST_XFER_A);
    cov_staged: cover property ($rose(SLV_B.req));
    cov_contend: cover property (state == ST_IDLE && !$onehot0(pend));
endmodule
`default_nettype wire

// ### hdl/dma_seq_consts.svh
// Constants for the channel DMA sequencers
`ifndef DMA_SEQ_CONSTS_SVH
`define DMA_SEQ_CONSTS_SVH
`define SEQ_P2D        3'h0
`define SEQ_S2P        3'h1
`define SEQ_P2S        3'h2
`define SEQ_D2S        3'h3
`define SEQ_S2D        3'h4
`define DSCR_BASE      16'h0000
`define DSCR_W_ADDR0   2'h0
`define DSCR_W_ADDR1   2'h1
`define DSCR_W_CTRL    2'h2
`define DSCR_W_STATUS  2'h3
`define CTRL_SIZE_MSB  15
`define CTRL_SWAP_BIT  16
`define CTRL_CKRST_BIT 17
`define STAT_DONE_BIT  31
`define STAT_OVR_BIT   30
`define FIFO_BASE      32'h0000F000
`define CHUNK_MAX      9'h100
`endif

// ### hdl/dma_seq_pkg.sv
// Types shared by the channel DMA sequencers
package dma_seq_pkg;
    typedef struct packed {
        logic        req;
        logic [31:0] src;
        logic [31:0] dst;
        logic [8:0]  len;
        logic        swap;
        logic        cksum_rst;
    } xfer_req_t;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_FETCH  = 7'h02,
        ST_ISSUE  = 7'h04,
        ST_XFER_A = 7'h08,
        ST_XFER_B = 7'h10,
        ST_STATUS = 7'h20,
        ST_DONE   = 7'h40
    } seq_state_t;
endpackage

// ### testbench/dma_far_side.sv
// Far-side model: Sram port and slave sequencers
`timescale 1ns/1ps
`default_nettype none
module far_slave
    import dma_seq_pkg::*;
#(
    parameter int STEP = 64,
    parameter int LAT  = 1
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire dma_seq_pkg::xfer_req_t rq,
    output logic                        ack,
    output logic [8:0]                  size,
    output dma_seq_pkg::xfer_req_t      last,
    output logic [15:0]                 n
);
    logic [8:0] got;
    logic [8:0] part;
    logic       req_q;
    int         cnt;
    assign part = (rq.len - got > 9'(STEP)) ? 9'(STEP) : rq.len - got;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack <= 1'b0;
            req_q <= 1'b0;
            got <= 9'h000;
            cnt <= 0;
            n <= 16'h0000;
        end
        else
        begin
            ack <= 1'b0;
            req_q <= rq.req;
            if (rq.req && !req_q)
            begin
                last <= rq;
                n <= n + 16'h0001;
            end
            if (!rq.req)
                got <= 9'h000;
            else if (!ack && cnt >= LAT)
            begin
                ack <= 1'b1;
                size <= part;
                got <= got + part;
                cnt <= 0;
            end
            else if (!ack)
                cnt <= cnt + 1;
        end
    end
endmodule

module dma_far_side
    import dma_seq_pkg::*;
#(
    parameter int KIND = 0
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [15:0]            size_w,
    input  wire logic                   sram_req,
    input  wire logic                   sram_wr,
    input  wire logic [15:0]            sram_addr,
    input  wire logic [31:0]            sram_wdata,
    output logic                        sram_ack,
    output logic [31:0]                 sram_rdata,
    input  wire dma_seq_pkg::xfer_req_t a,
    output logic                        a_ack,
    output logic [8:0]                  a_size,
    input  wire dma_seq_pkg::xfer_req_t b,
    output logic                        b_ack,
    output logic [8:0]                  b_size,
    output dma_seq_pkg::xfer_req_t      a_last,
    output dma_seq_pkg::xfer_req_t      b_last,
    output logic [15:0]                 n_a,
    output logic [15:0]                 n_b,
    output logic [15:0]                 st_addr,
    output logic [31:0]                 st_word,
    output logic                        early
);
    logic [31:0] word;
    logic [1:0]  nrd;
    int          cnt;
    // Checksum and swap bits always set, the sequencer must mask them
    assign word = (sram_addr[3:2] == 2'h0) ? 32'h10000000 + sram_addr[8:4]
        : (sram_addr[3:2] == 2'h1) ? 32'h20000000 + sram_addr[8:4]
        : {14'h0000, 2'h3, size_w};
    // Released data bus shows the inverse, never a stale match
    assign sram_rdata = sram_ack ? word : ~word;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sram_ack <= 1'b0;
            cnt <= 0;
            nrd <= 2'h0;
            early <= 1'b0;
        end
        else
        begin
            sram_ack <= 1'b0;
            if (sram_req && !sram_ack && cnt >= KIND)
            begin
                sram_ack <= 1'b1;
                cnt <= 0;
            end
            else if (sram_req && !sram_ack)
                cnt <= cnt + 1;
            if (sram_ack && !sram_wr && nrd != 2'h3)
                nrd <= nrd + 2'h1;
            if (sram_ack && sram_wr)
            begin
                nrd <= 2'h0;
                st_addr <= sram_addr;
                st_word <= sram_wdata;
            end
            if ((a.req || b.req) && nrd != 2'h3)
                early <= 1'b1;
        end
    end
    far_slave #(.STEP(64 + 32 * KIND), .LAT(KIND)) sa (.clk(clk), .rst(rst),
        .rq(a), .ack(a_ack), .size(a_size), .last(a_last), .n(n_a));
    far_slave #(.STEP(256), .LAT(1)) sb (.clk(clk), .rst(rst),
        .rq(b), .ack(b_ack), .size(b_size), .last(b_last), .n(n_b));
endmodule
`default_nettype wire

// ### testbench/channel_dma_sequencers_tb_top.sv
// Bench for all five sequencer kinds side by side
`timescale 1ns/1ps
`default_nettype none
`include "dma_seq_consts.svh"
module channel_dma_sequencers_tb_top;
    import dma_seq_pkg::*;
    logic        CLK_SYS;
    logic        SYS_RST;
    logic [31:0] CHAN_REQ;
    logic [15:0] size_w;
    logic [31:0] done [5];
    logic        busy [5];
    xfer_req_t   a_last [5];
    xfer_req_t   b_last [5];
    logic [15:0] n_a [5];
    logic [15:0] n_b [5];
    logic [15:0] st_addr [5];
    logic [31:0] st_word [5];
    logic        early [5];
    int          dcnt [5][32];
    int          nine_at4 [5];
    int          n_errors = 0;
    int          checks = 0;
    for (genvar k = 0; k < 5; k++)
    begin : g
        logic        sreq, swr, sack, aack, back;
        logic [15:0] saddr;
        logic [31:0] swd, srd;
        logic [8:0]  asz, bsz;
        xfer_req_t   a, b;
        channel_dma_sequencers #(.SEQ_KIND(3'(k))) dut (.CLK_SYS(CLK_SYS),
            .SYS_RST(SYS_RST), .CHAN_REQ(CHAN_REQ), .CHAN_DONE(done[k]),
            .SRAM_REQ(sreq), .SRAM_WR(swr), .SRAM_ADDR(saddr),
            .SRAM_WDATA(swd), .SRAM_ACK(sack), .SRAM_RDATA(srd), .SLV_A(a),
            .SLV_A_ACK(aack), .SLV_A_SIZE(asz), .SLV_B(b), .SLV_B_ACK(back),
            .SLV_B_SIZE(bsz), .BUSY(busy[k]));
        dma_far_side #(.KIND(k)) fs (.clk(CLK_SYS), .rst(SYS_RST),
            .size_w(size_w), .sram_req(sreq), .sram_wr(swr),
            .sram_addr(saddr), .sram_wdata(swd), .sram_ack(sack),
            .sram_rdata(srd), .a(a), .a_ack(aack), .a_size(asz), .b(b),
            .b_ack(back), .b_size(bsz), .a_last(a_last[k]),
            .b_last(b_last[k]), .n_a(n_a[k]), .n_b(n_b[k]),
            .st_addr(st_addr[k]), .st_word(st_word[k]), .early(early[k]));
    end
    initial
    begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    // Done pulses last one cycle, so count them as they pass
    // Kinds run at different speeds, so order is judged per kind
    always @(posedge CLK_SYS)
        for (int k = 0; k < 5; k++)
            for (int i = 0; i < 32; i++)
                if (done[k][i] === 1'b1)
                begin
                    if (i == 4)
                        nine_at4[k] = dcnt[k][9];
                    dcnt[k][i]++;
                end
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_done(input int ch, input int c0 [5]);
        int t;
        int left;
        for (t = 0; t < 30000; t++)
        begin
            left = 0;
            for (int k = 0; k < 5; k++)
                if (dcnt[k][ch] == c0[k])
                    left++;
            if (left == 0)
                break;
            @(posedge CLK_SYS);
        end
        for (int k = 0; k < 5; k++)
            chk("done count", 32'(c0[k] + 1), 32'(dcnt[k][ch]));
    endtask
    // One descriptor job on every kind, judged against the descriptor
    task automatic job(input int ch, input logic [15:0] sz);
        int          c0 [5];
        int          na0 [5];
        int          nb0 [5];
        int          nch;
        logic [31:0] off, w0, w1, src, dst;
        nch = (int'(sz) + 255) / 256;
        off = 32'((nch - 1) * 256);
        w0 = 32'h10000000 + 32'(ch);
        w1 = 32'h20000000 + 32'(ch);
        for (int k = 0; k < 5; k++)
        begin
            c0[k] = dcnt[k][ch];
            na0[k] = int'(n_a[k]);
            nb0[k] = int'(n_b[k]);
        end
        @(posedge CLK_SYS);
        size_w <= sz;
        CHAN_REQ[ch] <= 1'b1;
        wait_done(ch, c0);
        CHAN_REQ[ch] <= 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            src = (k == 1 || k == 3) ? w0 : w1;
            dst = (k == 1 || k == 3) ? w1 : w0;
            chk("fetch first", 32'h0, 32'(early[k]));
            chk("status addr", 32'(ch * 16 + 12), 32'(st_addr[k]));
            chk("status word", {16'h8000, sz}, st_word[k]);
            chk("a chunks", 32'(nch), 32'(int'(n_a[k]) - na0[k]));
            chk("b chunks", k == 0 ? 32'(nch) : 32'h0,
                32'(int'(n_b[k]) - nb0[k]));
            if (sz != 16'h0000)
            begin
                chk("a src", src + off, a_last[k].src);
                chk("a dst", k == 0 ? `FIFO_BASE : dst + off,
                    a_last[k].dst);
                chk("a len", 32'(sz) - off, 32'(a_last[k].len));
                chk("swap", 32'(k < 3), 32'(a_last[k].swap));
                chk("cksum", 32'(k == 4 && nch == 1),
                    32'(a_last[k].cksum_rst));
            end
            if (k == 0 && sz != 16'h0000)
            begin
                chk("b src", `FIFO_BASE, b_last[0].src);
                chk("b dst", w0 + off, b_last[0].dst);
                chk("b len", 32'(sz) - off, 32'(b_last[0].len));
            end
        end
    endtask
    // Two channels at once, then a level held with no new edge
    task automatic prio();
        int c9 [5];
        int c4 [5];
        for (int k = 0; k < 5; k++)
        begin
            c9[k] = dcnt[k][9];
            c4[k] = dcnt[k][4];
        end
        @(posedge CLK_SYS);
        size_w <= 16'h0010;
        CHAN_REQ <= 32'h00000210;
        wait_done(4, c4);
        for (int k = 0; k < 5; k++)
            chk("high chan waits", 32'(c9[k]), 32'(nine_at4[k]));
        wait_done(9, c9);
        repeat (200) @(posedge CLK_SYS);
        for (int k = 0; k < 5; k++)
            chk("held level", 32'(c9[k] + 1), 32'(dcnt[k][9]));
        CHAN_REQ <= 32'h00000000;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge CLK_SYS);
        n_errors++;
        summarize();
    end
    initial
    begin
        SYS_RST = 1'b1;
        CHAN_REQ = 32'h00000000;
        size_w = 16'h0000;
        repeat (20) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        for (int k = 0; k < 5; k++)
        begin
            chk("idle done", 32'h0, done[k]);
            chk("idle busy", 32'h0, 32'(busy[k]));
        end
        job(3, 16'h0008);
        job(31, 16'h0258);
        job(0, 16'h0000);
        job(7, 16'h0100);
        prio();
        job(12, 16'h0101);
        summarize();
    end
endmodule
`default_nettype wire
